// *** acmc_top.sv ***
/*
 * converter operating-mode and internal calibration controller with an
 * AXI4-Lite register port.
 * assumes conv_result is the filter output on the same clock, valid at
 * each conversion tick; rst_n may be asynchronous.
 */
// Our own choices: the AXI4-Lite slave port and the address map.
// Overview of operation
// - power-down switches off every powered circuit
// - zero-scale calibration shorts the enabled input
// - zero-scale calibration takes two conversion cycles
// - data-ready high at calibration start, low at end
// - finished calibration drops automatically into idle
// - zero-scale result goes to channel offset register
// - full-scale calibration applies internal full-scale voltage
// - gain one full-scale calibration takes two cycles
// - higher gain full-scale calibration takes four cycles (top gain code refused)
// - full-scale result goes to channel full-scale register
// - idle holds filter, modulator reset, clocks running
`timescale 1ns/10ps
module acmc_top import acmc_pkg::*; #(
  parameter int unsigned CONV_CYC_P = CONV_CYC,
  parameter int NUM_CH = 3,
  parameter int COEF_W = 24
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // filter result
  input wire logic [COEF_W-1:0] conv_result,
  // analogue controls
  output logic rdy_n,
  output logic excitation_en,
  output logic burnout_en,
  output logic bias_gen_en,
  output logic clock_output_driver_en,
  output logic modulator_clk_en,
  output logic filter_reset,
  output logic input_short_en,
  output logic fs_ref_en
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_pipe_q;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_q[1];

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    logic [3:0] sel;
    sel = SEL_NONE;
    if (addr == REG_MODE) begin
      sel = 4'h0;
    end else if (addr == REG_CONFIG) begin
      sel = 4'h1;
    end else if (addr == REG_STATUS) begin
      sel = 4'h2;
    end else if (addr == REG_DATA) begin
      sel = 4'h3;
    end else if (addr >= REG_OFFS_BASE && addr < REG_OFFS_BASE + 8'(4 * NUM_CH)
                 && addr[1:0] == 2'b00) begin
      sel = 4'h4 + 4'((addr - REG_OFFS_BASE) >> 2);
    end else if (addr >= REG_FS_BASE && addr < REG_FS_BASE + 8'(4 * NUM_CH)
                 && addr[1:0] == 2'b00) begin
      sel = 4'h8 + 4'((addr - REG_FS_BASE) >> 2);
    end
    return sel;
  endfunction : reg_sel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic aw_hold_q, w_hold_q, bvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [3:0] wsel;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign wsel = reg_sel(awaddr_q);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == SEL_NONE || wsel == 4'h3) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ****************************************
  // mode and configuration fields
  // ****************************************
  acmc_state_t state_q, state_d;
  logic [2:0] gain_q;
  logic [1:0] chan_q;
  logic [3:0] cfg_q;
  logic [31:0] mode_view, mode_new;
  logic mode_wr;
  logic [2:0] wr_mode, wr_gain;
  logic [1:0] wr_chan;

  always_comb begin
    mode_view = 32'h0;
    mode_view[MODE_SEL_LSB +: 3] = state_q;
    mode_view[MODE_GAIN_LSB +: 3] = gain_q;
    mode_view[MODE_CHAN_LSB +: 2] = chan_q;
  end
  assign mode_new = merge(mode_view, wdata_q, wstrb_q);
  assign mode_wr = do_write && wsel == 4'h0;
  assign wr_mode = mode_new[MODE_SEL_LSB +: 3];
  assign wr_gain = mode_new[MODE_GAIN_LSB +: 3];
  assign wr_chan = mode_new[MODE_CHAN_LSB +: 2];

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gain_q <= GAIN_RST;
      chan_q <= CHAN_RST;
    end else if (mode_wr) begin
      gain_q <= wr_gain;
      chan_q <= wr_chan;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_q <= CFG_RST;
    end else if (do_write && wsel == 4'h1) begin
      cfg_q <= 4'(merge({28'h0, cfg_q}, wdata_q, wstrb_q));
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  acmc_cal_if cal ();
  logic start_op, refuse, zs_wr, fs_wr, data_upd, cal_busy;
  logic [2:0] target_d, target_q;

  acmc_rate_div #(.CYC(CONV_CYC_P)) acmc_rate_div_inst (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .link(cal.div)
  );

  acmc_cyc_cnt acmc_cyc_cnt_inst (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .link(cal.cnt)
  );

  always_comb begin
    state_d = state_q;
    start_op = 1'b0;
    refuse = 1'b0;
    zs_wr = 1'b0;
    fs_wr = 1'b0;
    data_upd = 1'b0;
    target_d = FIRST_CONV;
    if (mode_wr) begin
      case (wr_mode)
        ST_FCAL: begin
          if (wr_gain == GAIN_MAX) begin
            refuse = 1'b1;
            state_d = ST_IDLE;
          end else begin
            start_op = 1'b1;
            state_d = ST_FCAL;
            target_d = (wr_gain == GAIN_ONE) ? FS_CAL_CONV_G1 : FS_CAL_CONV_GN;
          end
        end
        ST_ZCAL: begin
          start_op = 1'b1;
          state_d = ST_ZCAL;
          target_d = ZS_CAL_CONV;
        end
        ST_CONT, ST_SINGLE: begin
          start_op = 1'b1;
          state_d = acmc_state_t'(wr_mode);
        end
        ST_PDOWN: state_d = ST_PDOWN;
        default: state_d = ST_IDLE;
      endcase
    end else begin
      case (state_q)
        ST_ZCAL: begin
          if (cal.done) begin
            zs_wr = 1'b1;
            state_d = ST_IDLE;
          end
        end
        ST_FCAL: begin
          if (cal.done) begin
            fs_wr = 1'b1;
            state_d = ST_IDLE;
          end
        end
        ST_SINGLE: begin
          if (cal.done) begin
            data_upd = 1'b1;
            state_d = ST_PDOWN;
          end
        end
        ST_CONT: data_upd = cal.done || (cal.tick && cal.count == target_q);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= ST_CONT;
      target_q <= FIRST_CONV;
    end else begin
      state_q <= state_d;
      if (start_op) begin
        target_q <= target_d;
      end
    end
  end

  assign cal.restart = start_op;
  assign cal.run = state_q == ST_CONT || state_q == ST_SINGLE || cal_busy;
  assign cal.target = target_q;
  assign cal_busy = state_q == ST_ZCAL || state_q == ST_FCAL;

  // ****************************************
  // coefficients, data and flags
  // ****************************************
  logic [COEF_W-1:0] offs_q [NUM_CH];
  logic [COEF_W-1:0] fs_q [NUM_CH];
  logic [COEF_W-1:0] data_q;
  logic rdy_n_q, refused_q, data_rd;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_coef
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        offs_q[c] <= OFFS_RST;
        fs_q[c] <= FS_RST;
      end else begin
        if (zs_wr && chan_q == 2'(c)) begin
          offs_q[c] <= conv_result;
        end else if (do_write && wsel == 4'h4 + 4'(c)) begin
          offs_q[c] <= COEF_W'(merge(32'(offs_q[c]), wdata_q, wstrb_q));
        end
        if (fs_wr && chan_q == 2'(c)) begin
          fs_q[c] <= conv_result;
        end else if (do_write && wsel == 4'h8 + 4'(c)) begin
          fs_q[c] <= COEF_W'(merge(32'(fs_q[c]), wdata_q, wstrb_q));
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_q <= '0;
      rdy_n_q <= 1'b1;
    end else begin
      if (data_upd) begin
        data_q <= conv_result;
      end
      if (zs_wr || fs_wr || data_upd) begin
        rdy_n_q <= 1'b0;
      end else if (start_op || data_rd) begin
        rdy_n_q <= 1'b1;
      end
    end
  end
  assign rdy_n = rdy_n_q;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refused_q <= 1'b0;
    end else if (refuse) begin
      refused_q <= 1'b1;
    end else if (do_write && wsel == 4'h2 && wstrb_q[0] && wdata_q[STS_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // ****************************************
  // analogue controls
  // ****************************************
  logic pwr_on;
  assign pwr_on = state_d != ST_PDOWN;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      excitation_en <= 1'b0;
      burnout_en <= 1'b0;
      bias_gen_en <= 1'b0;
      clock_output_driver_en <= 1'b0;
      modulator_clk_en <= 1'b1;
      filter_reset <= 1'b0;
      input_short_en <= 1'b0;
      fs_ref_en <= 1'b0;
    end else begin
      excitation_en <= pwr_on && cfg_q[CFG_EXC_BIT];
      burnout_en <= pwr_on && cfg_q[CFG_BURN_BIT];
      bias_gen_en <= pwr_on && cfg_q[CFG_BIAS_BIT];
      clock_output_driver_en <= pwr_on && cfg_q[CFG_CLK_DRV_BIT];
      modulator_clk_en <= pwr_on;
      filter_reset <= state_d == ST_IDLE || state_d == ST_PDOWN;
      input_short_en <= state_d == ST_ZCAL;
      fs_ref_en <= state_d == ST_FCAL;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic rvalid_q;
  logic [31:0] rdata_q, rmux;
  logic [1:0] rresp_q;
  logic [3:0] rsel;

  assign rsel = reg_sel(s_axi_araddr);
  assign s_axi_arready = !rvalid_q;
  assign data_rd = s_axi_arvalid && s_axi_arready && rsel == 4'h3;

  always_comb begin
    rmux = 32'h0;
    if (rsel == 4'h0) begin
      rmux = mode_view;
    end else if (rsel == 4'h1) begin
      rmux[3:0] = cfg_q;
    end else if (rsel == 4'h2) begin
      rmux[STS_RDY_BIT] = rdy_n_q;
      rmux[STS_BUSY_BIT] = cal_busy;
      rmux[STS_REFUSED_BIT] = refused_q;
      rmux[STS_STATE_LSB +: 3] = state_q;
    end else if (rsel == 4'h3) begin
      rmux[COEF_W-1:0] = data_q;
    end else if (rsel >= 4'h4 && rsel < 4'h4 + 4'(NUM_CH)) begin
      rmux[COEF_W-1:0] = offs_q[2'(rsel - 4'h4)];
    end else if (rsel >= 4'h8 && rsel < 4'h8 + 4'(NUM_CH)) begin
      rmux[COEF_W-1:0] = fs_q[2'(rsel - 4'h8)];
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rmux;
      rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  sequence zs_finish_s;
    state_q == ST_ZCAL && cal.tick && cal.count == 3'h1 && !mode_wr;
  endsequence
  sequence fs_finish_s;
    state_q == ST_FCAL && cal.done && !mode_wr;
  endsequence

  pd_all_off_a: assert property (state_q == ST_PDOWN |-> !excitation_en && !burnout_en
      && !bias_gen_en && !clock_output_driver_en && !modulator_clk_en)
    else $error("power-down left a circuit enabled");
  zs_short_on_a: assert property (state_q == ST_ZCAL |-> input_short_en && !fs_ref_en)
    else $error("zero-scale without input short");
  zs_two_conv_a: assert property (zs_finish_s |=> state_q == ST_IDLE ##0 !rdy_n)
    else $error("zero-scale did not end at second conversion");
  cal_rdy_high_a: assert property (mode_wr && wr_mode == ST_ZCAL
      |=> rdy_n throughout (state_q == ST_ZCAL) [*2])
    else $error("data-ready not high during calibration");
  cal_to_idle_a: assert property (cal_busy && cal.done && !mode_wr |=> state_q == ST_IDLE)
    else $error("calibration did not enter idle");
  offs_stored_a: assert property (zs_finish_s and chan_q == 2'h0
      |=> offs_q[0] == $past(conv_result))
    else $error("offset coefficient not stored");
  fs_ref_on_a: assert property (state_q == ST_FCAL |-> fs_ref_en && !input_short_en)
    else $error("full-scale voltage not applied");
  fs_gain1_len_a: assert property (state_q == ST_FCAL && gain_q == GAIN_ONE
      |-> cal.count <= 3'h1)
    else $error("gain-one full-scale calibration too long");
  fs_gainn_len_a: assert property (fs_finish_s and gain_q != GAIN_ONE
      |-> cal.count == 3'h3)
    else $error("high-gain full-scale calibration not four cycles");
  fs_stored_a: assert property (fs_finish_s and chan_q == 2'h0
      |=> fs_q[0] == $past(conv_result) && !rdy_n)
    else $error("full-scale coefficient not stored");
  idle_reset_a: assert property (state_q == ST_IDLE |-> filter_reset && modulator_clk_en)
    else $error("idle not holding filter in reset");
  fs_refused_a: assert property (mode_wr && wr_mode == ST_FCAL && wr_gain == GAIN_MAX
      |=> state_q == ST_IDLE && refused_q && fs_q[0] == $past(fs_q[0]))
    else $error("gain-128 full-scale calibration not refused");

endmodule : acmc_top

// *** acmc_pkg.sv ***
/*
 * constants, field layout and state encoding for the converter mode and
 * calibration controller.
 * assumes a single 200 MHz clock and a 32-bit AXI4-Lite register port.
 */
package acmc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CONV_PERIOD_NS = 60_000_000;
  localparam int unsigned CONV_CYC = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] ZS_CAL_CONV = 3'h2;
  localparam logic [2:0] FS_CAL_CONV_G1 = 3'h2;
  localparam logic [2:0] FS_CAL_CONV_GN = 3'h4;
  localparam logic [2:0] FIRST_CONV = 3'h2;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_OFFS_BASE = 8'h10;
  localparam logic [7:0] REG_FS_BASE = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_GAIN_LSB = 4;
  localparam int MODE_CHAN_LSB = 8;
  localparam int CFG_EXC_BIT = 0;
  localparam int CFG_BURN_BIT = 1;
  localparam int CFG_BIAS_BIT = 2;
  localparam int CFG_CLK_DRV_BIT = 3;
  localparam int STS_RDY_BIT = 0;
  localparam int STS_BUSY_BIT = 1;
  localparam int STS_REFUSED_BIT = 2;
  localparam int STS_STATE_LSB = 4;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [2:0] GAIN_ONE = 3'h0;
  localparam logic [2:0] GAIN_MAX = 3'h7;
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [1:0] CHAN_RST = 2'h0;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [23:0] OFFS_RST = 24'h800000;
  localparam logic [23:0] FS_RST = 24'h500000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] SEL_NONE = 4'hf;

  typedef enum logic [2:0] {
    ST_CONT = 3'b000,
    ST_SINGLE = 3'b001,
    ST_IDLE = 3'b010,
    ST_PDOWN = 3'b011,
    ST_ZCAL = 3'b100,
    ST_FCAL = 3'b101
  } acmc_state_t;

endpackage : acmc_pkg

// *** acmc_cal_if.sv ***
/*
 * link between the controller, the conversion-rate divider and the
 * conversion counter.
 * assumes all three sit on the same clock.
 */
`timescale 1ns/10ps
interface acmc_cal_if;
  logic restart;
  logic run;
  logic tick;
  logic done;
  logic [2:0] target;
  logic [2:0] count;

  modport ctrl (output restart, output run, output target, input tick, input done, input count);
  modport div (input restart, input run, output tick);
  modport cnt (input restart, input tick, input target, output done, output count);
endinterface : acmc_cal_if

// *** acmc_rate_div.sv ***
/*
 * conversion-rate divider: one-cycle tick per conversion period.
 * assumes restart and run come from logic on the same clock.
 */
`timescale 1ns/10ps
module acmc_rate_div #(
  parameter int unsigned CYC = 12000000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // controller link
  acmc_cal_if.div link
);
  localparam logic [31:0] LAST = 32'(CYC - 1);
  logic [31:0] cnt_q;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_q <= 32'h0;
    end else if (link.restart || !link.run || cnt_q == LAST) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign link.tick = link.run && !link.restart && (cnt_q == LAST);
endmodule : acmc_rate_div

// *** acmc_cyc_cnt.sv ***
/*
 * counts conversion ticks up to a target, flags the final one.
 * assumes tick from the rate divider on the same clock.
 */
`timescale 1ns/10ps
module acmc_cyc_cnt (
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // controller link
  acmc_cal_if.cnt link
);
  logic [2:0] count_q;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count_q <= 3'h0;
    end else if (link.restart) begin
      count_q <= 3'h0;
    end else if (link.tick && count_q != link.target) begin
      count_q <= count_q + 3'h1;
    end
  end

  assign link.count = count_q;
  assign link.done = link.tick && (count_q == link.target - 3'h1);
endmodule : acmc_cyc_cnt

// *** acmc_host_model.sv ***
/*
 * host side of the register port: a plain AXI4-Lite master with wr and rd tasks.
 * assumes the slave shares the clock; hangs counts waits that ran out.
 */
`timescale 1ns/10ps
module acmc_host_model (
  // clock
  input wire logic clock,
  // write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int hangs = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw_t, w_t, b_t;
    k = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      // slave outputs settle mid-cycle and hold to the next edge
      @(negedge clock);
      aw_t = s_axi_awready;
      w_t = s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      k++;
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t && k < 60);
    s_axi_bready <= 1'b0;
    // released payload no longer shows the last word
    s_axi_wdata <= ~d;
    if (k >= 60) hangs++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ar_t, r_t;
    k = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar_t = s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      k++;
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t && k < 60);
    s_axi_rready <= 1'b0;
    if (k >= 60) hangs++;
  endtask : rd
endmodule : acmc_host_model

// *** adc_calibration_mode_control_tb.sv ***
/*
 * self-checking bench for the mode and calibration controller.
 * assumes the host model on the register port; the bench drives the filter result.
 */
`timescale 1ns/10ps
module adc_calibration_mode_control_tb;
  import acmc_pkg::*;
  localparam int C = 10;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] conv_result = '0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rdy_n, excitation_en, burnout_en, bias_gen_en, clock_output_driver_en;
  logic modulator_clk_en, filter_reset, input_short_en, fs_ref_en;
  int failures = 0;
  int n_tests = 0;
  int seed = 11;
  int offs[3];
  int fsc[3];
  int g, kw;
  logic [23:0] sv;

  acmc_top #(.CONV_CYC_P(C)) acmc_top_inst (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result, .rdy_n, .excitation_en,
    .burnout_en, .bias_gen_en, .clock_output_driver_en, .modulator_clk_en, .filter_reset,
    .input_short_en, .fs_ref_en);
  acmc_host_model acmc_host_model_inst (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic hang_test;
    if (acmc_host_model_inst.hangs > 0) begin
      failures++;
      close_out();
    end
  endtask : hang_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    acmc_host_model_inst.wr(a, d, r);
    hang_test();
    check(r, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] d;
    acmc_host_model_inst.rd(a, d, r);
    hang_test();
    check(r, er);
    if (er == RESP_OKAY) check(d, exp);
  endtask : rd

  task automatic wait_rdy(output int k);
    k = 0;
    while (rdy_n !== 1'b0 && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 200) begin
      failures++;
      close_out();
    end
  endtask : wait_rdy

  // one internal calibration, then result, state and coefficients against the model
  task automatic cal(input int mode, input int gain, input int ch, input int n);
    logic [23:0] v;
    int k;
    v = 24'($random(seed));
    conv_result <= v;
    wr(REG_MODE, 32'((ch << 8) | (gain << 4) | mode), RESP_OKAY);
    #1;
    check({rdy_n, filter_reset}, 2'b10);
    check({input_short_en, fs_ref_en}, (mode == 4) ? 2'b10 : 2'b01);
    wait_rdy(k);
    check(32'(k >= n * C - 2 && k <= n * C + 1), 32'h1);
    check({input_short_en, fs_ref_en, filter_reset, modulator_clk_en}, 4'b0011);
    if (mode == 4) offs[ch] = v;
    else fsc[ch] = v;
    rd(REG_STATUS, 32'h20, RESP_OKAY);
    rd(8'(REG_OFFS_BASE + 4 * ch), offs[ch], RESP_OKAY);
    rd(8'(REG_FS_BASE + 4 * ch), fsc[ch], RESP_OKAY);
  endtask : cal

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int ch = 0; ch < 3; ch++) begin
      offs[ch] = 32'h800000;
      fsc[ch] = 32'h500000;
      rd(8'(REG_OFFS_BASE + 4 * ch), offs[ch], RESP_OKAY);
      rd(8'(REG_FS_BASE + 4 * ch), fsc[ch], RESP_OKAY);
    end
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_DATA, 32'h0, RESP_SLVERR);
    for (int ch = 0; ch < 3; ch++) cal(4, 0, ch, 2);
    cal(4, 3, 1, 2);
    cal(5, 0, 0, 2);
    g = 1 + (($random(seed) & 32'h7fff) % 6);
    cal(5, g, 2, 4);
    conv_result <= 24'($random(seed));
    wr(REG_MODE, 32'h175, RESP_OKAY);
    repeat (4 * C + 5) @(posedge clock);
    rd(REG_STATUS, 32'h24, RESP_OKAY);
    rd(REG_FS_BASE + 8'h04, fsc[1], RESP_OKAY);
    wr(REG_CONFIG, 32'hf, RESP_OKAY);
    wr(REG_MODE, 32'h0, RESP_OKAY);
    #1;
    check({excitation_en, burnout_en, bias_gen_en, clock_output_driver_en}, 4'hf);
    wr(REG_MODE, 32'h3, RESP_OKAY);
    #1;
    check({excitation_en, burnout_en, bias_gen_en, clock_output_driver_en,
           modulator_clk_en}, 5'h00);
    // single conversion, data read, sticky refused flag cleared
    sv = 24'($random(seed));
    conv_result <= sv;
    wr(REG_MODE, 32'h1, RESP_OKAY);
    wait_rdy(kw);
    check(32'(kw >= 2 * C - 2 && kw <= 2 * C + 1), 32'h1);
    rd(REG_STATUS, 32'h34, RESP_OKAY);
    rd(REG_DATA, {8'h0, sv}, RESP_OKAY);
    rd(REG_STATUS, 32'h35, RESP_OKAY);
    wr(REG_STATUS, 32'h4, RESP_OKAY);
    rd(REG_STATUS, 32'h31, RESP_OKAY);
    close_out();
  end
endmodule : adc_calibration_mode_control_tb
